// [ohf_pkg.sv]
// package: constants and types for the overcurrent hiccup fault control block
// How it works
// [R1] overcurrent while high side is on ends the pulse at once
// [R2] after overcurrent termination high side stays low until next cycle start
// [R3] blanking starts just before high-side turn-on, threshold pulled to half supply; here blanking and high side start in the same cycle
// [R4] blanking ends when switch node nears supply, after reaction delay
// [R5] internal timeout ends blanking if switch node never rises
// [R6] overcurrent ignored during blanking
// [R7] fault counter increments each cycle with an overcurrent pulse
// [R8] fault counter decrements each clean cycle
// [R9] count of seven declares fault and forces gate outputs to fault state
// [R10] fault disables pwm and runs seven soft-start cycles with gates quiet
// [R11] counter decrements at end of each recovery soft-start cycle
// [R12] counter at zero re-enables pwm and restarts with soft start
// [R13] persistent overcurrent repeats the hiccup indefinitely
// [R14] reference is lower of shifted ramp and internal reference
// [R15] driver regulator mode has hysteresis between two supply levels
// [R16] fault rectifier level: off for source-only, on for source-sink
// [R17] soft-start ramp is the recovery timebase
// [R18] counter saturates at zero and clears on lockout reset
// [R19] ramp-top crossing gives a one-cycle soft-start done pulse
package ohf_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned REACT_NS = 20;
  localparam int unsigned REACT_CYC =
    ((REACT_NS * (CLK_HZ / 1_000_000) + 999) / 1000 < 1) ? 1 :
    (REACT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned BLANK_TO_NS = 300;
  localparam int unsigned BLANK_TO_CYC =
    (BLANK_TO_NS * (CLK_HZ / 1_000_000) / 1000 < 1) ? 1 :
    BLANK_TO_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam logic [2:0] FAULT_LIMIT = 3'h7;
  localparam logic [2:0] CNT_ZERO = 3'h0;
  localparam int unsigned MV_W = 16;
  localparam logic [MV_W-1:0] SS_SHIFT_MV = 16'h03E8;
  localparam logic [MV_W-1:0] REF_MV = 16'h02BC;
  localparam logic [MV_W-1:0] LDO_BELOW_MV = 16'h2134;
  localparam logic [MV_W-1:0] REG_ABOVE_MV = 16'h2710;
  localparam logic [MV_W-1:0] SS_TOP_MV = 16'h06A4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BLANK = 2'b01,
    ST_ON = 2'b10,
    ST_OFF = 2'b11
  } ohf_phase_type;

  typedef struct packed {
    logic high_side_gate_drive;
    logic low_side_gate_drive;
    logic threshold_pull;
  } ohf_gate_type;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] oc_s;
    logic [1:0] sw_s;
    logic [1:0] pwm_s;
    logic [1:0] cyc_s;
    logic [1:0] ss_top_s;
    logic ss_top_d;
    logic cyc_d;
    ohf_phase_type phase;
    logic [7:0] tmr;
    logic oc_seen;
    logic [2:0] fault_cnt;
    logic fault;
    logic regulated_mode;
    logic ss_done;
    ohf_gate_type gate;
    logic [MV_W-1:0] ref_mv;
  } ohf_state_type;
endpackage

// [ohf_top.sv]
// module: pulse limit, blanking, hiccup fault counter, reference and regulator mode
`timescale 1ns/100ps
`default_nettype none
module ohf_top import ohf_pkg::*; #(
  parameter bit SINK_VARIANT = 1'b1,
  parameter int unsigned BLANK_CYC = BLANK_TO_CYC
) (
  // clock and lockout reset
  input wire logic mclk,
  input wire logic arst_n,
  // cycle and pwm from oscillator and comparator
  input wire logic cycle_start,
  input wire logic pwm_request,
  // power stage sense
  input wire logic overcurrent_cmp,
  input wire logic switch_node_sense,
  // analog levels as millivolt codes
  input wire logic [MV_W-1:0] soft_start_mv,
  input wire logic [MV_W-1:0] supply_mv,
  // gate and threshold outputs
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  output logic current_limit_threshold,
  // status
  output logic fault_active,
  output logic [2:0] fault_count,
  output logic soft_start_done,
  output logic driver_supply_regulator,
  output logic [MV_W-1:0] regulation_ref_mv
);
  ohf_state_type s_r, s_nxt;
  logic rst_n;
  logic cyc_edge;
  logic [MV_W-1:0] shifted;

  assign rst_n = s_r.rst_sync[1];
  assign cyc_edge = s_r.cyc_s[1] & ~s_r.cyc_d;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rst_sync = s_r.rst_sync;
    s_nxt.oc_s = {s_r.oc_s[0], overcurrent_cmp};
    s_nxt.sw_s = {s_r.sw_s[0], switch_node_sense};
    s_nxt.pwm_s = {s_r.pwm_s[0], pwm_request};
    s_nxt.cyc_s = {s_r.cyc_s[0], cycle_start};
    s_nxt.ss_top_s = {s_r.ss_top_s[0], (soft_start_mv >= SS_TOP_MV)};
    s_nxt.cyc_d = s_r.cyc_s[1];
    s_nxt.ss_top_d = s_r.ss_top_s[1];
    s_nxt.ss_done = s_r.ss_top_s[1] & ~s_r.ss_top_d; // [R19] [R17]
    // shifted ramp floors at zero below the offset
    shifted = (soft_start_mv > SS_SHIFT_MV) ? soft_start_mv - SS_SHIFT_MV : '0;
    s_nxt.ref_mv = (shifted < REF_MV) ? shifted : REF_MV; // [R14]
    if (supply_mv < LDO_BELOW_MV) begin
      s_nxt.regulated_mode = 1'b0; // [R15]
    end else if (supply_mv > REG_ABOVE_MV) begin
      s_nxt.regulated_mode = 1'b1; // [R15]
    end
    if (s_r.fault) begin
      // hiccup: pwm off, gates held, counter walks down on each ramp
      s_nxt.phase = ST_IDLE; // [R10]
      if (s_r.ss_done) begin
        s_nxt.fault_cnt = s_r.fault_cnt - 3'h1; // [R11] [R17]
        if (s_r.fault_cnt == 3'h1) begin
          s_nxt.fault = 1'b0; // [R12]
        end
      end
    end else if (cyc_edge) begin
      // close out previous cycle
      if (s_r.oc_seen) begin
        s_nxt.fault_cnt = s_r.fault_cnt + 3'h1; // [R7]
        if (s_r.fault_cnt + 3'h1 == FAULT_LIMIT) begin
          s_nxt.fault = 1'b1; // [R9] [R13]
        end
      end else if (s_r.fault_cnt != CNT_ZERO) begin
        s_nxt.fault_cnt = s_r.fault_cnt - 3'h1; // [R8] [R18]
      end
      s_nxt.oc_seen = 1'b0;
      s_nxt.tmr = 8'h00;
      // blanking begins in the same cycle as the high side turns on
      s_nxt.phase = s_r.pwm_s[1] ? ST_BLANK : ST_OFF; // [R3]
    end else begin
      case (s_r.phase)
        ST_BLANK: begin
          s_nxt.tmr = s_r.tmr + 8'h01;
          if (!s_r.pwm_s[1]) begin
            s_nxt.phase = ST_OFF;
          end else if (s_r.sw_s[1] && s_r.tmr >= 8'(REACT_CYC - 1)) begin
            s_nxt.phase = ST_ON; // [R4]
          end else if (s_r.tmr >= 8'(BLANK_CYC - 1)) begin
            s_nxt.phase = ST_ON; // [R5]
          end
        end
        ST_ON: begin
          // sensing only counts once the threshold is released
          if (s_r.oc_s[1]) begin
            s_nxt.oc_seen = 1'b1; // [R6]
            s_nxt.phase = ST_OFF; // [R1] [R2]
          end else if (!s_r.pwm_s[1]) begin
            s_nxt.phase = ST_OFF;
          end
        end
        ST_OFF: s_nxt.phase = ST_OFF; // [R2]
        ST_IDLE: s_nxt.phase = ST_IDLE;
        default: s_nxt.phase = ST_IDLE;
      endcase
    end
    // gate outputs from next phase; fault overrides
    s_nxt.gate.high_side_gate_drive = (s_nxt.phase == ST_ON) || (s_nxt.phase == ST_BLANK);
    s_nxt.gate.low_side_gate_drive = (s_nxt.phase == ST_OFF);
    s_nxt.gate.threshold_pull = (s_nxt.phase == ST_BLANK); // [R3]
    if (s_nxt.fault) begin
      s_nxt.gate.high_side_gate_drive = 1'b0; // [R9] [R10]
      s_nxt.gate.low_side_gate_drive = SINK_VARIANT; // [R16]
      s_nxt.gate.threshold_pull = 1'b0;
    end
    s_nxt.ss_done = s_nxt.ss_done;
  end

  // one register process for the whole state, so no field has two drivers;
  // lockout asserts at once but releases through the two-flop sync
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_r.rst_sync <= 2'h0;
      s_r.oc_s <= 2'h0;
      s_r.sw_s <= 2'h0;
      s_r.pwm_s <= 2'h0;
      s_r.cyc_s <= 2'h0;
      s_r.ss_top_s <= 2'h0;
      s_r.ss_top_d <= 1'b0;
      s_r.cyc_d <= 1'b0;
      s_r.phase <= ST_IDLE;
      s_r.tmr <= 8'h00;
      s_r.oc_seen <= 1'b0;
      s_r.fault_cnt <= 3'h0; // [R18]
      s_r.fault <= 1'b0;
      s_r.regulated_mode <= 1'b0;
      s_r.ss_done <= 1'b0;
      s_r.gate <= '0;
      s_r.ref_mv <= '0;
    end else if (!rst_n) begin
      s_r.rst_sync <= {s_r.rst_sync[0], 1'b1};
      s_r.phase <= ST_IDLE;
      s_r.fault_cnt <= 3'h0;
      s_r.fault <= 1'b0;
      s_r.gate <= '0;
    end else begin
      s_r.rst_sync <= {s_r.rst_sync[0], 1'b1};
      s_r.oc_s <= s_nxt.oc_s;
      s_r.sw_s <= s_nxt.sw_s;
      s_r.pwm_s <= s_nxt.pwm_s;
      s_r.cyc_s <= s_nxt.cyc_s;
      s_r.ss_top_s <= s_nxt.ss_top_s;
      s_r.ss_top_d <= s_nxt.ss_top_d;
      s_r.cyc_d <= s_nxt.cyc_d;
      s_r.phase <= s_nxt.phase;
      s_r.tmr <= s_nxt.tmr;
      s_r.oc_seen <= s_nxt.oc_seen;
      s_r.fault_cnt <= s_nxt.fault_cnt;
      s_r.fault <= s_nxt.fault;
      s_r.regulated_mode <= s_nxt.regulated_mode;
      s_r.ss_done <= s_nxt.ss_done;
      s_r.gate <= s_nxt.gate;
      s_r.ref_mv <= s_nxt.ref_mv;
    end
  end

  assign high_side_gate_drive = s_r.gate.high_side_gate_drive;
  assign low_side_gate_drive = s_r.gate.low_side_gate_drive;
  assign current_limit_threshold = s_r.gate.threshold_pull;
  assign fault_active = s_r.fault;
  assign fault_count = s_r.fault_cnt;
  assign soft_start_done = s_r.ss_done;
  assign driver_supply_regulator = s_r.regulated_mode;
  assign regulation_ref_mv = s_r.ref_mv;
endmodule
`default_nettype wire

// [ohf_sva.sv]
// checker: port assertions for the hiccup fault control block
`timescale 1ns/100ps
`default_nettype none
module ohf_sva import ohf_pkg::*; #(
  parameter bit SINK_VARIANT = 1'b1
) (
  input wire logic mclk, arst_n, cycle_start, pwm_request, overcurrent_cmp, switch_node_sense,
  input wire logic [MV_W-1:0] soft_start_mv, supply_mv, regulation_ref_mv,
  input wire logic high_side_gate_drive, low_side_gate_drive, current_limit_threshold,
  input wire logic fault_active, soft_start_done, driver_supply_regulator,
  input wire logic [2:0] fault_count
);
  logic [MV_W-1:0] ref_x;
  logic band;
  // ramp below the shift gives a zero reference, never a wrapped one
  assign ref_x = (soft_start_mv < SS_SHIFT_MV) ? '0 :
    ((soft_start_mv - SS_SHIFT_MV < REF_MV) ? soft_start_mv - SS_SHIFT_MV : REF_MV);
  assign band = supply_mv >= LDO_BELOW_MV && supply_mv <= REG_ABOVE_MV;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_oc_ends_pulse: assert property ((overcurrent_cmp && !current_limit_threshold)[*5]
    |-> !high_side_gate_drive) else $error("pulse kept past overcurrent");
  a_blank_with_hs: assert property (current_limit_threshold |-> high_side_gate_drive)
    else $error("blanking without high side");
  a_blank_bound: assert property ($rose(current_limit_threshold)
    |-> ##[1:5] !current_limit_threshold) else $error("blanking too long");
  a_fault_seven: assert property ($rose(fault_active) |-> fault_count == FAULT_LIMIT)
    else $error("fault at wrong count");
  a_fault_gates: assert property (fault_active && $past(fault_active) |->
    !high_side_gate_drive && low_side_gate_drive == SINK_VARIANT) else $error("gates in fault");
  a_count_step: assert property ($changed(fault_count) |->
    fault_count - $past(fault_count) == 3'h1 || $past(fault_count) - fault_count == 3'h1)
    else $error("counter jumped");
  a_recover_down: assert property (fault_active && $past(fault_active) && $changed(fault_count)
    |-> fault_count == $past(fault_count) - 3'h1) else $error("recovery count wrong");
  a_done_pulse: assert property (soft_start_done |=> !soft_start_done)
    else $error("done pulse too long");
  a_ref_value: assert property ($stable(soft_start_mv)[*6] |-> regulation_ref_mv == ref_x)
    else $error("reference wrong");
  a_mode_low: assert property ((supply_mv < LDO_BELOW_MV)[*6] |-> !driver_supply_regulator)
    else $error("mode not dropout");
  a_mode_high: assert property ((supply_mv > REG_ABOVE_MV)[*6] |-> driver_supply_regulator)
    else $error("mode not regulated");
  a_mode_hold: assert property (band[*6] |-> $stable(driver_supply_regulator))
    else $error("mode moved in band");
endmodule
bind ohf_top ohf_sva #(.SINK_VARIANT(SINK_VARIANT)) sva_u (.*);
`default_nettype wire

// [ohf_stage.sv]
// partner: power stage sense and soft-start ramp
`timescale 1ns/100ps
`default_nettype none
module ohf_stage import ohf_pkg::*; (
  input wire logic mclk, short_on, sw_stuck, fault_active, high_side_gate_drive,
  output logic overcurrent_cmp, switch_node_sense,
  output logic [MV_W-1:0] soft_start_mv
);
  logic [2:0] div = 3'h0;
  logic fa_d = 1'b0;
  initial {overcurrent_cmp, switch_node_sense, soft_start_mv} = '0;
  always @(negedge mclk) begin
    switch_node_sense <= high_side_gate_drive && !sw_stuck;
    overcurrent_cmp <= high_side_gate_drive && short_on;
    fa_d <= fault_active;
    div <= div + 3'h1;
    // ramp discharges on fault entry and exit, and repeats while in fault
    if (fault_active != fa_d) soft_start_mv <= '0;
    else if (div == 3'h0 && soft_start_mv < 16'h07D0) soft_start_mv <= soft_start_mv + 16'h0032;
    else if (div == 3'h0 && fault_active) soft_start_mv <= '0;
  end
endmodule
`default_nettype wire

// [overcurrent_hiccup_fault_control_test.sv]
// testbench: random cycles with shorts against a counting model
`timescale 1ns/100ps
`default_nettype none
module overcurrent_hiccup_fault_control_test;
  import ohf_pkg::*;
  logic mclk = 0, arst_n = 0, cycle_start = 0, pwm_request = 0, short_on = 0, sw_stuck = 0;
  logic overcurrent_cmp, switch_node_sense, high_side_gate_drive, low_side_gate_drive;
  logic current_limit_threshold, fault_active, soft_start_done, driver_supply_regulator, fa_q;
  logic [MV_W-1:0] soft_start_mv, regulation_ref_mv, supply_mv = 16'h2328;
  logic [2:0] fault_count;
  logic [31:0] r;
  int num_errors = 0, cmp_count = 0, seed, ecnt, pulses = 0, emode, i, j, skip, hit;
  always #50 mclk = ~mclk;
  ohf_stage stage_u (.*);
  ohf_top dut_u (.*);
  // sample away from the launching edge so the count sees settled outputs
  always @(negedge mclk) begin
    fa_q <= fault_active;
    if (soft_start_done && (fault_active || fa_q)) pulses++;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #3000000;
    num_errors++;
    conclude;
  end
  initial begin
    seed = 32'h993fc35b;
    ecnt = 0;
    emode = 0;
    repeat (3) @(negedge mclk);
    arst_n = 1;
    repeat (4) @(negedge mclk);
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      // two forced bursts, twenty cycles apart, give two hiccups in the run
      pwm_request = r[1] | (i % 20 < 8 && i > 10);
      short_on = r[0] & r[5] | (i % 20 < 8 && i > 10);
      sw_stuck = r[2];
      supply_mv = r[4] ? (r[3] ? 16'h2AF8 : 16'h1F40) : 16'h2328;
      hit = short_on && pwm_request;
      skip = 0;
      cycle_start = 1;
      repeat (2) @(negedge mclk);
      cycle_start = 0;
      repeat (6) @(negedge mclk);
      if (ecnt == 7) begin
        chk(fault_active, 1);
        chk({high_side_gate_drive, low_side_gate_drive}, 2'b01);
        for (j = 0; j < 3000 && fault_active !== 1'b0; j++) @(negedge mclk);
        chk(pulses, 7);
        chk(fault_count, 0);
        pulses = 0;
        ecnt = 0;
        skip = 1;
      end else chk(fault_count, ecnt);
      if (supply_mv < 16'h2134) emode = 0;
      else if (supply_mv > 16'h2710) emode = 1;
      chk(driver_supply_regulator, emode);
      repeat (11) @(negedge mclk);
      if (hit) chk(high_side_gate_drive, 0);
      if (!skip) ecnt = hit ? ecnt + 1 : (ecnt > 0 ? ecnt - 1 : 0);
    end
    conclude;
  end
endmodule
`default_nettype wire
